// ### logic/cmd_parser.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module cmd_parser (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Instrument side
  input  wire logic        ifc_n,
  output logic             bus_hold,
  output logic             srq,
  output logic             zero_go,
  output logic             cal_go,
  output logic      [4:0]  srq_status,
  output logic      [2:0]  range_out
);
  typedef struct packed {
    cmd_pkg::mode_t     mode;
    logic [15:0]        acc;
    logic               have_num;
    logic               neg;
    logic               frac;
    logic [15:0]        stor0;
    logic [15:0]        stor1;
    logic [15:0]        stor2;
    logic [15:0]        stor3;
    logic [15:0]        stor4;
    logic [15:0]        shown;
    cmd_pkg::arms_t     arms;
    logic [2:0]         rng;
    logic [2:0]         zlo;
    logic [2:0]         zhi;
    logic [cmd_pkg::ZERO_CYC_W-1:0] zcnt;
    logic               pending;
    logic               done_srq;
    logic               busy_done;
    logic [4:0]         status;
    logic [31:0]        rdata;
    logic               ready;
    logic               err;
    logic               zero_p;
    logic               cal_p;
    logic [1:0]         ifc_s;
    logic [2:0]         apparent;
  } state_t;

  state_t s_q, s_d;
  cmd_pkg::cmd_t cmd;
  logic [2:0] app_rng;

  cmd_decode u_dec (
    .ch  (pwdata[7:0]),
    .cmd (cmd)
  );

  range_map u_map (
    .internal_rng (s_q.rng),
    .apparent_rng (app_rng)
  );

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    hit = (a[7:2] == b[7:2]);
  endfunction : hit

  logic access;
  logic [15:0] fixed_val;
  assign access = psel && penable && !s_q.ready;
  assign fixed_val = s_q.neg ? 16'(-s_q.acc) : s_q.acc; // [RULE3]

  always_comb begin
    s_d = s_q;
    s_d.ifc_s = {s_q.ifc_s[0], ifc_n};
    s_d.ready = 1'b0;
    s_d.err = 1'b0;
    s_d.zero_p = 1'b0;
    s_d.cal_p = 1'b0;
    s_d.apparent = app_rng;
    if (s_q.mode == cmd_pkg::ST_BUSY) begin
      if (s_q.zcnt == '0) begin
        s_d.mode = cmd_pkg::ST_MEAS; // [RULE13]
        s_d.busy_done = 1'b1;
      end else begin
        s_d.zcnt = s_q.zcnt - 1'b1;
      end
    end
    if (!s_q.ifc_s[1]) begin
      s_d.arms = '0; // [RULE19]
    end
    if (access) begin
      s_d.ready = 1'b1;
      s_d.rdata = '0;
      if (pwrite && hit(paddr, cmd_pkg::A_RXCHAR)) begin
        if (s_q.mode == cmd_pkg::ST_BUSY) begin
          s_d.ready = 1'b0; // [RULE18]
        end else if (cmd.digit) begin
          s_d.have_num = 1'b1;
          if (!s_q.frac) begin
            s_d.acc = 16'(s_q.acc * 16'h000A + {12'h000, cmd.digit_val}); // [RULE2]
          end
        end else if (cmd.point || cmd.exp_mark) begin
          s_d.frac = 1'b1;
        end else if (cmd.sign) begin
          s_d.neg = 1'b1;
        end else if (cmd != '0) begin // [RULE21]
          s_d.have_num = 1'b0;
          s_d.acc = '0;
          s_d.neg = 1'b0;
          s_d.frac = 1'b0;
          if (cmd.key_meas) begin
            s_d.mode = cmd_pkg::ST_MEAS; // [RULE20]
          end else if (cmd.key_data) begin
            if (s_q.have_num) begin
              case (cmd.data_idx)
                3'h0: s_d.stor0 = fixed_val;
                3'h1: s_d.stor1 = fixed_val;
                3'h2: s_d.stor2 = fixed_val;
                3'h3: s_d.stor3 = fixed_val;
                default: s_d.stor4 = fixed_val;
              endcase
              s_d.mode = cmd_pkg::ST_MEAS; // [RULE8]
            end else begin
              case (cmd.data_idx)
                3'h0: s_d.shown = s_q.stor0;
                3'h1: s_d.shown = s_q.stor1;
                3'h2: s_d.shown = s_q.stor2;
                3'h3: s_d.shown = s_q.stor3;
                default: s_d.shown = s_q.stor4;
              endcase
              s_d.mode = cmd_pkg::ST_ENTRY; // [RULE7]
            end
          end else if (cmd.arm_cmd) begin
            s_d.mode = cmd_pkg::ST_MEAS; // [RULE20]
            case (cmd.arm_sel)
              2'h0: s_d.arms.hold = s_q.have_num && s_q.acc != '0;
              2'h1: s_d.arms.srq = s_q.have_num && s_q.acc != '0;
              2'h2: s_d.arms.raw = s_q.have_num && s_q.acc != '0;
              default: s_d.arms.limit = s_q.have_num && s_q.acc != '0;
            endcase
          end else if (cmd.zero) begin
            s_d.zero_p = 1'b1; // [RULE9]
          end else if (cmd.clr) begin
            s_d.shown = '0; // [RULE9]
          end else if (cmd.cal) begin
            s_d.cal_p = 1'b1; // [RULE9]
          end else if (cmd.rng_set) begin
            s_d.rng = s_q.acc[2:0]; // [RULE12] [RULE10]
            s_d.mode = cmd_pkg::ST_MEAS;
          end else if (cmd.rng_zero) begin
            s_d.zlo = 3'(s_q.acc / 16'h000A); // [RULE11] [RULE10]
            s_d.zhi = 3'(s_q.acc % 16'h000A);
            s_d.zcnt = cmd_pkg::ZERO_CYC_W'(cmd_pkg::ZERO_CYC_1 + cmd_pkg::ZERO_CYC_STEP
                       * int'(3'(s_q.acc % 16'h000A) - 3'(s_q.acc / 16'h000A))); // [RULE14]
            s_d.mode = cmd_pkg::ST_BUSY; // [RULE16]
          end
        end
      end else if (pwrite && hit(paddr, cmd_pkg::A_CTRL)) begin
        s_d.arms = pwdata[3:0];
        if (pwdata[4]) begin
          s_d.arms = '0; // [RULE19]
        end
      end else if (pwrite && hit(paddr, cmd_pkg::A_MEAS)) begin
        if (s_q.arms.limit) begin
          s_d.status = {1'b0, pwdata[3:0]}; // [RULE4] [RULE5] [RULE6]
          if (pwdata[3:0] != 4'h0) begin
            s_d.arms.limit = 1'b0;
          end
        end
      end else if (!pwrite && hit(paddr, cmd_pkg::A_STATUS)) begin
        s_d.rdata = {24'h0, 1'b0, s_q.busy_done, s_q.mode, s_q.status[3:0]};
        s_d.busy_done = 1'b0;
        s_d.status = '0;
      end else if (!pwrite && hit(paddr, cmd_pkg::A_VALUE)) begin
        s_d.rdata = {16'h0, s_q.shown};
      end else if (!pwrite && hit(paddr, cmd_pkg::A_RANGE)) begin
        s_d.rdata = {26'h0, s_q.apparent, s_q.rng}; // [RULE15]
      end else if (!pwrite && hit(paddr, cmd_pkg::A_CTRL)) begin
        s_d.rdata = {28'h0, s_q.arms};
      end else if (!hit(paddr, cmd_pkg::A_LIMSET)) begin
        s_d.err = 1'b1;
      end
    end
    if (s_q.mode == cmd_pkg::ST_BUSY && s_d.mode == cmd_pkg::ST_MEAS && s_q.arms.srq) begin
      s_d.done_srq = 1'b1; // [RULE17]
    end else if (access && !pwrite && hit(paddr, cmd_pkg::A_STATUS)) begin
      s_d.done_srq = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ifc_s <= 2'b11;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign bus_hold = s_q.mode == cmd_pkg::ST_BUSY; // [RULE16]
  assign srq = s_q.done_srq;
  assign zero_go = s_q.zero_p;
  assign cal_go = s_q.cal_p;
  assign srq_status = s_q.status;
  assign range_out = s_q.apparent;

  a_zero_done: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == cmd_pkg::ST_BUSY && s_q.zcnt == '0 && clk_en) |=> s_q.mode == cmd_pkg::ST_MEAS)
    else $error("zero did not finish"); // [RULE13]
  a_ifc_disarm: assert property (@(posedge pclk) disable iff (!presetn)
    (!s_q.ifc_s[1] && clk_en && !access) |=> s_q.arms == '0)
    else $error("clear did not disarm"); // [RULE19]
  a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.mode == cmd_pkg::ST_BUSY) |-> bus_hold)
    else $error("bus not held"); // [RULE18]

  // Accepted character write while not busy
  sequence s_char_write;
    access && pwrite && hit(paddr, cmd_pkg::A_RXCHAR) && s_q.mode != cmd_pkg::ST_BUSY && clk_en;
  endsequence

  a_store_meas: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    (s_char_write ##0 (cmd.key_data && s_q.have_num)) |=> s_q.mode == cmd_pkg::ST_MEAS)
    else $error("store did not return to measuring");
  a_undef_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE21]
    (s_char_write ##0 (cmd == '0)) |=> (s_q.acc == $past(s_q.acc) && s_q.mode == $past(s_q.mode)))
    else $error("undefined character changed state");
  a_cal_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (cal_go && clk_en) |=> !cal_go)
    else $error("calibrate pulse too long");
  a_limit_code: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    (access && pwrite && hit(paddr, cmd_pkg::A_MEAS) && s_q.arms.limit && clk_en)
    |=> srq_status == {1'b0, $past(pwdata[3:0])})
    else $error("limit code not reported");
endmodule : cmd_parser

// ### logic/cmd_pkg.sv
// How it works
// [RULE1] Each command byte acts exactly like the matching front-panel key press.
// [RULE2] Numbers in fixed or floating notation are converted to one fixed value.
// [RULE3] Sign is attached after conversion so naturally written signed numbers work.
// [RULE4] Service request status is a five-bit code, one bit pair per channel limit.
// [RULE5] Channel one low limit reports 01, high limit 10, in bits 1:0.
// [RULE6] Channel two low limit reports 01, high limit 10, in bits 3:2.
// [RULE7] Data-entry commands store a preceding number, otherwise recall the stored constant.
// [RULE8] After a data-entry store the block returns to measuring.
// [RULE9] Zero starts auto zeroing, clear zeroes the entry, calibrate runs 1 mW calibration.
// [RULE10] Controller always gives range-zero and range-set a numeric argument.
// [RULE11] Range-zero argument digits give first and last range, inclusive.
// [RULE12] Range-set loads the internal range from its argument, 0 to 7.
// [RULE13] Range-zero finishes within 2.3 s for one range up to 4.3 s for seven.
// [RULE14] Range-zero stores offsets without waiting for a settled zero.
// [RULE15] Internal range maps onto a separate apparent range code for output.
// [RULE16] The bus is held while a received string executes.
// [RULE17] Optionally a service request signals that string processing finished; the code raises srq only when a range-zero ends.
// [RULE18] A second string during execution holds the bus until execution ends.
// [RULE19] Interface or device clear disarms hold, service, raw-data and limit arms.
// [RULE20] Mode, trigger and arm commands leave store/recall and resume measuring.
// [RULE21] Undefined characters are ignored and change nothing.
package cmd_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned ZERO_MS_1   = 2300;
  localparam int unsigned ZERO_MS_STEP = 333;
  localparam int unsigned ZERO_CYC_1  = CLK_HZ / 1000 * ZERO_MS_1;
  localparam int unsigned ZERO_CYC_STEP = CLK_HZ / 1000 * ZERO_MS_STEP;
  localparam int unsigned ZERO_CYC_W  = 28;

  localparam logic [31:0] A_CTRL   = 32'h0000_0000;
  localparam logic [31:0] A_RXCHAR = 32'h0000_0004;
  localparam logic [31:0] A_STATUS = 32'h0000_0008;
  localparam logic [31:0] A_VALUE  = 32'h0000_000C;
  localparam logic [31:0] A_LIMSET = 32'h0000_0010;
  localparam logic [31:0] A_MEAS   = 32'h0000_0014;
  localparam logic [31:0] A_RANGE  = 32'h0000_0018;

  localparam logic [15:0] RST_VAL  = 16'h0000;
  localparam logic [2:0]  RST_RANGE = 3'h0;
  localparam int unsigned N_CONST  = 5;

  typedef enum logic [1:0] {
    ST_MEAS = 2'b00,
    ST_ENTRY = 2'b01,
    ST_BUSY = 2'b11
  } mode_t;

  typedef struct packed {
    logic       key_meas;
    logic       key_data;
    logic [2:0] data_idx;
    logic       digit;
    logic [3:0] digit_val;
    logic       sign;
    logic       point;
    logic       exp_mark;
    logic       zero;
    logic       clr;
    logic       cal;
    logic       rng_zero;
    logic       rng_set;
    logic       arm_cmd;
    logic [1:0] arm_sel;
  } cmd_t;

  typedef struct packed {
    logic hold;
    logic srq;
    logic raw;
    logic limit;
  } arms_t;
endpackage : cmd_pkg

// ### logic/cmd_decode.sv
`timescale 1ns/1ps
module cmd_decode (
  // Character in
  input  wire logic [7:0]   ch,
  // Decoded command
  output cmd_pkg::cmd_t     cmd
);
  always_comb begin
    cmd = '0;
    case (ch)
      8'h50, 8'h42, 8'h41, 8'h4F, 8'h54: cmd.key_meas = 1'b1; // [RULE1] [RULE20]
      8'h4C: begin cmd.key_data = 1'b1; cmd.data_idx = 3'h0; end // [RULE7]
      8'h48: begin cmd.key_data = 1'b1; cmd.data_idx = 3'h1; end
      8'h4E: begin cmd.key_data = 1'b1; cmd.data_idx = 3'h2; end
      8'h52: begin cmd.key_data = 1'b1; cmd.data_idx = 3'h3; end
      8'h53: begin cmd.key_data = 1'b1; cmd.data_idx = 3'h4; end
      8'h5A: cmd.zero = 1'b1;
      8'h43: cmd.clr = 1'b1;
      8'h4B: cmd.cal = 1'b1;
      8'h59: cmd.rng_zero = 1'b1;
      8'h47: cmd.rng_set = 1'b1;
      8'h51: begin cmd.arm_cmd = 1'b1; cmd.arm_sel = 2'h0; end
      8'h56: begin cmd.arm_cmd = 1'b1; cmd.arm_sel = 2'h1; end
      8'h4A: begin cmd.arm_cmd = 1'b1; cmd.arm_sel = 2'h2; end
      8'h55: begin cmd.arm_cmd = 1'b1; cmd.arm_sel = 2'h3; end
      8'h2D: cmd.sign = 1'b1; // [RULE3]
      8'h2B: ;
      8'h2E: cmd.point = 1'b1; // [RULE2]
      8'h45: cmd.exp_mark = 1'b1;
      default: begin
        if (ch >= 8'h30 && ch <= 8'h39) begin
          cmd.digit     = 1'b1;
          cmd.digit_val = ch[3:0];
        end
      end // [RULE21]
    endcase
  end
endmodule : cmd_decode

// ### logic/range_map.sv
`timescale 1ns/1ps
module range_map (
  // Internal range
  input  wire logic [2:0] internal_rng,
  // Apparent range code
  output logic      [2:0] apparent_rng
);
  always_comb begin
    case (internal_rng)
      3'h6: apparent_rng = 3'h6; // [RULE15]
      3'h5: apparent_rng = 3'h5;
      3'h4: apparent_rng = 3'h4;
      3'h3: apparent_rng = 3'h3;
      3'h2: apparent_rng = 3'h2;
      3'h1: apparent_rng = 3'h1;
      3'h0: apparent_rng = 3'h0;
      3'h7: apparent_rng = 3'h7;
      default: apparent_rng = 3'h0;
    endcase
  end
endmodule : range_map

// ### tb/bus_ctl.sv
`timescale 1ns/1ps
module bus_ctl (
  // Clock
  input  wire logic        pclk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  // APB answer
  input  wire logic        pready
);
  // Expected pslverr of each transfer, oldest first
  logic exp_q[$];
  // Expected prdata of each transfer, bit 32 set when it is checked
  logic [32:0] dat_q[$];

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0000_0000;
    pwdata  = 32'h0000_0000;
  end

  // One APB transfer, held until pready
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                      input logic err, input logic [32:0] rexp);
    exp_q.push_back(err);
    dat_q.push_back(rexp);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data does not keep its value
    pwdata  <= ~data;
  endtask : xfer

  task automatic send_char(input logic [7:0] ch);
    xfer(1'b1, cmd_pkg::A_RXCHAR, {24'h00_0000, ch}, 1'b0, 33'h0_0000_0000);
  endtask : send_char

  // Argument digit always comes before the command
  task automatic send_arg(input logic [3:0] n, input logic [7:0] ch);
    send_char(8'h30 + {4'h0, n});
    send_char(ch);
  endtask : send_arg
endmodule : bus_ctl

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ifc_n;
  logic        bus_hold;
  logic        srq;
  logic        zero_go;
  logic        cal_go;
  logic [4:0]  srq_status;
  logic [2:0]  range_out;
  logic        exp_e;
  logic [32:0] exp_d;
  logic [2:0]  r;
  int          failures;
  int          comparisons;
  int          nz;
  int          nc;
  int          seed_v;

  cmd_parser dut_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ifc_n(ifc_n), .bus_hold(bus_hold), .srq(srq), .zero_go(zero_go),
    .cal_go(cal_go), .srq_status(srq_status), .range_out(range_out)
  );

  bus_ctl ctl_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready)
  );

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Answer monitor takes the oldest note at every completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      exp_e = ctl_u.exp_q.pop_front();
      exp_d = ctl_u.dat_q.pop_front();
      chk("pslverr", {31'h0, pslverr}, {31'h0, exp_e});
      if (exp_d[32]) chk("prdata", prdata, exp_d[31:0]);
    end
    if (zero_go === 1'b1) nz++;
    if (cal_go === 1'b1) nc++;
  end

  task automatic wait_rng(input logic [2:0] want);
    for (int k = 0; k < 20 && range_out !== want; k++) @(posedge pclk);
    chk("range_out", {29'h0, range_out}, {29'h0, want});
  endtask : wait_rng

  task automatic wait_cnt;
    for (int k = 0; k < 20 && nz + nc == 0; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : wait_cnt

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done();
  end

  initial begin
    presetn = 1'b0;
    clk_en  = 1'b1;
    ifc_n   = 1'b1;
    seed_v  = $urandom(32'h43C9);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("srq_status", {27'h0, srq_status}, 32'h0000_0000);
    chk("bus_hold", {31'h0, bus_hold}, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      ctl_u.send_arg(i[3:0], 8'h47);
      wait_rng(i[2:0]);
    end
    repeat (4) begin
      r = 3'($urandom % 8);
      ctl_u.send_arg({1'b0, r}, 8'h47);
      wait_rng(r);
    end
    ctl_u.send_arg(4'h5, 8'h47);
    wait_rng(3'h5);
    ctl_u.send_char(8'h33);
    ctl_u.send_char(8'h7E);
    repeat (5) @(posedge pclk);
    chk("range_out", {29'h0, range_out}, 32'h0000_0005);
    ctl_u.send_char(8'h47);
    wait_rng(3'h3);
    ctl_u.xfer(1'b0, 32'h0000_001C, 32'h0000_0000, 1'b1, 33'h0_0000_0000);
    ctl_u.xfer(1'b0, cmd_pkg::A_STATUS, 32'h0000_0000, 1'b0, 33'h1_0000_0000);
    ctl_u.send_char(8'h31);
    ctl_u.send_char(8'h32);
    ctl_u.send_char(8'h4C);
    ctl_u.xfer(1'b0, cmd_pkg::A_STATUS, 32'h0000_0000, 1'b0, 33'h1_0000_0000);
    ctl_u.send_char(8'h4C);
    ctl_u.xfer(1'b0, cmd_pkg::A_VALUE, 32'h0000_0000, 1'b0, 33'h1_0000_000C);
    ctl_u.xfer(1'b0, cmd_pkg::A_STATUS, 32'h0000_0000, 1'b0, 33'h1_0000_0010);
    ctl_u.send_char(8'h32);
    ctl_u.send_char(8'h2E);
    ctl_u.send_char(8'h35);
    ctl_u.send_char(8'h4E);
    ctl_u.send_char(8'h4E);
    ctl_u.xfer(1'b0, cmd_pkg::A_VALUE, 32'h0000_0000, 1'b0, 33'h1_0000_0002);
    ctl_u.send_char(8'h35);
    ctl_u.send_char(8'h2D);
    ctl_u.send_char(8'h48);
    ctl_u.send_char(8'h48);
    ctl_u.xfer(1'b0, cmd_pkg::A_VALUE, 32'h0000_0000, 1'b0, 33'h1_0000_FFFB);
    ctl_u.send_char(8'h43);
    ctl_u.xfer(1'b0, cmd_pkg::A_VALUE, 32'h0000_0000, 1'b0, 33'h1_0000_0000);
    ctl_u.xfer(1'b1, cmd_pkg::A_CTRL, 32'h0000_0001, 1'b0, 33'h0_0000_0000);
    ctl_u.xfer(1'b1, cmd_pkg::A_MEAS, 32'h0000_0006, 1'b0, 33'h0_0000_0000);
    chk("srq_status", {27'h0, srq_status}, 32'h0000_0006);
    ctl_u.xfer(1'b0, cmd_pkg::A_STATUS, 32'h0000_0000, 1'b0, 33'h1_0000_0016);
    ctl_u.xfer(1'b1, cmd_pkg::A_CTRL, 32'h0000_000F, 1'b0, 33'h0_0000_0000);
    ctl_u.xfer(1'b0, cmd_pkg::A_CTRL, 32'h0000_0000, 1'b0, 33'h1_0000_000F);
    ctl_u.send_char(8'h4B);
    wait_cnt();
    chk("cal_go", nc, 32'h0000_0001);
    chk("zero_go", nz, 32'h0000_0000);
    nc = 0;
    ctl_u.send_char(8'h5A);
    wait_cnt();
    chk("zero_go", nz, 32'h0000_0001);
    chk("cal_go", nc, 32'h0000_0000);
    @(posedge pclk);
    ifc_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ifc_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("srq", {31'h0, srq}, 32'h0000_0000);
    chk("srq_status", {27'h0, srq_status}, 32'h0000_0000);
    ctl_u.xfer(1'b0, cmd_pkg::A_CTRL, 32'h0000_0000, 1'b0, 33'h1_0000_0000);
    test_done();
  end
endmodule : testbench
